// file: rtl/flash_status_regs.svh
// Constants for the flash status polling controller
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH
`define DQ_W 8
`define BIT_TOGGLE_TWO 2
`define BIT_ERASE_TIMER 3
`define BIT_TIMING_LIMIT 5
`define BIT_TOGGLE_ONE 6
`define CMD_RESET 8'hF0
`define CMD_RESET_ADDR 20'h0_0000
// Read and write strobe lengths, in ns and in cycles of the 4 ns clock
`define CLK_NS 4
`define STROBE_NS 80
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_NS 40
`define GAP_CYC ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
// Erase time-out guard for extra sector erase commands
`define ERASE_GAP_US 50
`define ERASE_GAP_CYC ((`ERASE_GAP_US * 1000) / `CLK_NS)
`endif

// file: rtl/flash_status_pkg.sv
// Types for the flash status polling controller
package flash_status_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_READ1 = 4'b0001,
    ST_READ2 = 4'b0010,
    ST_CHECK = 4'b0011,
    ST_READ3 = 4'b0100,
    ST_READ4 = 4'b0101,
    ST_RECHECK = 4'b0110,
    ST_RESET_WR = 4'b0111,
    ST_DONE = 4'b1000
  } poll_state_e;

  typedef enum logic [1:0] {
    RES_OK = 2'b00,
    RES_FAIL = 2'b01,
    RES_ABORT = 2'b10
  } poll_result_e;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
  } flash_ctl_s;

  typedef struct packed {
    logic toggle_one;
    logic toggle_two;
    logic timing_limit;
    logic erase_timer;
  } status_bits_s;
endpackage : flash_status_pkg

// file: rtl/flash_status_poller.sv
// Host-side toggle bit poller driving the flash status pins
`timescale 1ns/100ps
`include "flash_status_regs.svh"

// How it works
// - Start polling with two reads; equal toggle bits mean done.
// - Still toggling: check limit flag, reread, reset on failure.
// - Resuming after abort restarts from the first double read.
// - After a limit failure write the reset command.
// - Timer check may be skipped if commands come within 50 us.
// - Confirm acceptance by toggle bit before reading timer bit; here both are latched together in ST_CHECK.
// - Check timer bit before and after each extra erase command; the poller only reports it, and the caller issues erase commands.
module flash_status_poller #(
  parameter int STROBE_CYC = `STROBE_CYC,
  parameter int GAP_CYC = `GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [19:0] i_addr,
  input wire logic [`DQ_W-1:0] i_dq,
  input wire logic i_ready_busy_n,
  output flash_status_pkg::flash_ctl_s o_ctl,
  output logic [`DQ_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_busy,
  output logic o_done,
  output flash_status_pkg::poll_result_e o_result,
  output flash_status_pkg::status_bits_s o_status,
  output logic o_ready
);
  import flash_status_pkg::*;

  poll_state_e state;
  poll_state_e next_state;
  logic [7:0] cnt;
  logic strobe_on;
  logic [`DQ_W-1:0] first_dq;
  logic [19:0] addr;
  logic cycle_end;
  logic is_read;
  logic toggling;
  logic limit_hit;
  logic [`DQ_W-1:0] next_first;
  logic [`DQ_W-1:0] second_dq;
  logic [`DQ_W-1:0] next_second;
  logic sample_end;
  logic abort_ok;

  // One bus cycle: strobe low for STROBE_CYC, then high for GAP_CYC
  assign cycle_end = !strobe_on && cnt == 8'(GAP_CYC - 1);
  assign is_read = state inside {ST_READ1, ST_READ2, ST_READ3, ST_READ4};
  // Both reads are latched in the last strobe-low cycle; the bus is
  // released by the time the compare states run, so it is never used live
  assign sample_end = strobe_on && cnt == 8'(STROBE_CYC - 1);
  assign toggling =
    first_dq[`BIT_TOGGLE_ONE] != second_dq[`BIT_TOGGLE_ONE];
  assign limit_hit = second_dq[`BIT_TIMING_LIMIT];
  assign next_first = (sample_end && state inside {ST_READ1, ST_READ3})
                      ? i_dq : first_dq;
  assign next_second = (sample_end && state inside {ST_READ2, ST_READ4})
                       ? i_dq : second_dq;
  // Abort is refused once a failure decision or the reset write is due
  assign abort_ok = i_abort
                    && !(state inside {ST_IDLE, ST_RECHECK, ST_RESET_WR});

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (i_start) next_state = ST_READ1;
      ST_READ1: if (cycle_end) next_state = ST_READ2;
      ST_READ2: if (cycle_end) next_state = ST_CHECK;
      ST_CHECK: begin
        if (!toggling) next_state = ST_DONE;
        else if (limit_hit) next_state = ST_READ3;
        else next_state = ST_READ1;
      end
      ST_READ3: if (cycle_end) next_state = ST_READ4;
      ST_READ4: if (cycle_end) next_state = ST_RECHECK;
      ST_RECHECK: next_state = toggling ? ST_RESET_WR : ST_DONE;
      ST_RESET_WR: if (cycle_end) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    // Abort drops the pass; a fresh start reruns from the double read
    if (abort_ok)
      next_state = ST_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      strobe_on <= 1'b0;
      first_dq <= 8'h00;
      second_dq <= 8'h00;
      addr <= 20'h0_0000;
    end else begin
      state <= next_state;
      first_dq <= next_first;
      second_dq <= next_second;
      if (state == ST_IDLE && i_start) addr <= i_addr;
      if (next_state != state || state inside {ST_CHECK, ST_RECHECK}) begin
        cnt <= 8'h00;
        strobe_on <= 1'b1;
      end else if (strobe_on && cnt == 8'(STROBE_CYC - 1)) begin
        cnt <= 8'h00;
        strobe_on <= 1'b0;
      end else if (!cycle_end) begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  // Pin and result registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h0_0000};
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_result <= RES_OK;
      o_status <= '0;
      o_ready <= 1'b0;
    end else begin
      o_ctl.ce_n <= !(strobe_on && (is_read || state == ST_RESET_WR));
      o_ctl.oe_n <= !(strobe_on && is_read);
      o_ctl.we_n <= !(strobe_on && state == ST_RESET_WR);
      o_ctl.addr <= (state == ST_RESET_WR) ? `CMD_RESET_ADDR : addr;
      o_dq <= `CMD_RESET;
      o_dq_oe <= state == ST_RESET_WR;
      o_busy <= state != ST_IDLE;
      o_done <= state == ST_DONE;
      // Pin level is only trusted once no write strobe is open
      o_ready <= i_ready_busy_n && o_ctl.we_n;
      if (state == ST_RECHECK && toggling) o_result <= RES_FAIL;
      else if (state inside {ST_CHECK, ST_RECHECK} && !toggling)
        o_result <= RES_OK;
      else if (abort_ok)
        o_result <= RES_ABORT;
      if (state == ST_CHECK) begin
        o_status.toggle_one <= toggling;
        o_status.toggle_two <= first_dq[`BIT_TOGGLE_TWO]
                               != second_dq[`BIT_TOGGLE_TWO];
        o_status.timing_limit <= limit_hit;
        // Timer bit is only reported, in the same cycle as the toggle compare;
        // the caller decides whether further erase commands are safe
        o_status.erase_timer <=
          second_dq[`BIT_ERASE_TIMER];
      end
    end
  end

  property p_reset_after_fail;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_RECHECK && toggling) |=> state == ST_RESET_WR;
  endproperty
  a_reset_after_fail: assert property (p_reset_after_fail)
    else $error("failure did not lead to reset write");

  property p_done_on_steady;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_CHECK && !toggling && !i_abort) |=> state == ST_DONE
      ##1 o_done;
  endproperty
  a_done_on_steady: assert property (p_done_on_steady)
    else $error("steady toggle bit did not finish");

  property p_limit_recheck;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_CHECK && toggling && limit_hit && !i_abort)
      |=> state == ST_READ3;
  endproperty
  a_limit_recheck: assert property (p_limit_recheck)
    else $error("limit flag did not cause recheck");

  property p_start_double_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_IDLE && i_start && !i_abort) |=> state == ST_READ1;
  endproperty
  a_start_double_read: assert property (p_start_double_read)
    else $error("start skipped first read");

  property p_reset_cmd_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
      !o_ctl.we_n |-> o_dq_oe && o_dq == `CMD_RESET;
  endproperty
  a_reset_cmd_drive: assert property (p_reset_cmd_drive)
    else $error("write strobe without reset command data");

  property p_no_overlap;
    @(posedge i_clk) disable iff (!i_rst_n)
      !(!o_ctl.oe_n && !o_ctl.we_n);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("read and write strobes overlap");

  property p_fail_result;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state == ST_RECHECK && toggling) |=> o_result == RES_FAIL;
  endproperty
  a_fail_result: assert property (p_fail_result)
    else $error("failure not reported");

  property p_addr_held;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!o_ctl.oe_n && $past(!o_ctl.oe_n)) |-> $stable(o_ctl.addr);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("status read address moved mid cycle");
endmodule : flash_status_poller

// file: verification/flash_status_model.sv
// Behavioural flash device answering toggle bit status reads
`timescale 1ns/100ps
`include "flash_status_regs.svh"
module flash_status_model (
  input wire flash_status_pkg::flash_ctl_s i_ctl,
  input wire logic [`DQ_W-1:0] i_dq,
  input wire logic i_load,
  input wire logic [7:0] i_reads,
  input wire logic i_fail,
  output logic [`DQ_W-1:0] o_dq,
  output logic o_ready_busy_n,
  output int o_resets
);
  import flash_status_pkg::*;
  logic [7:0] left = 8'h00;
  logic fail = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [`DQ_W-1:0] last = 8'h00;
  wire busy = fail || (left != 8'h00);
  wire rd = !i_ctl.ce_n && !i_ctl.oe_n;
  // Select and strobe move on one edge, so act on the combined pulse
  wire wr = !i_ctl.ce_n && !i_ctl.we_n;
  initial o_resets = 0;
  // Open drain with pull-up: released means high
  assign o_ready_busy_n = !busy;
  // Released bus shows the inverse so a stale value never passes
  assign o_dq = rd ? last : ~last;
  always @(posedge i_load) begin
    left = i_reads;
    fail = i_fail;
  end
  always @(posedge rd) begin
    if (busy) begin
      t1 = !t1;
      t2 = !t2;
      if (left != 8'h00) left = left - 8'h01;
      // Erase status: timer expired, limit flag as loaded
      last = {1'b0, t1, fail, 1'b0, 1'b1, t2, 2'b00};
    end else begin
      last = 8'h5A;
    end
  end
  always @(negedge wr) begin
    if (i_dq === `CMD_RESET) begin
      fail = 1'b0;
      left = 8'h00;
      o_resets = o_resets + 1;
    end
  end
endmodule : flash_status_model

// file: verification/testbench.sv
// Testbench for the toggle bit status poller
`timescale 1ns/100ps
`include "flash_status_regs.svh"
module testbench;
  import flash_status_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic i_abort = 1'b0;
  logic [19:0] i_addr = 20'h0_0000;
  logic load = 1'b0;
  logic [7:0] reads = 8'h00;
  logic fail = 1'b0;
  flash_ctl_s ctl;
  logic [`DQ_W-1:0] dev_dq;
  logic [`DQ_W-1:0] host_dq;
  logic dq_oe, busy, done, ready, rb_n;
  poll_result_e result;
  status_bits_s status;
  int resets;
  int n_errors = 0;
  int n_tests = 0;
  always #2 i_clk = ~i_clk;
  flash_status_poller #(.STROBE_CYC(2), .GAP_CYC(1)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_abort(i_abort), .i_addr(i_addr),
    .i_dq(dq_oe ? host_dq : dev_dq), .i_ready_busy_n(rb_n),
    .o_ctl(ctl), .o_dq(host_dq), .o_dq_oe(dq_oe), .o_busy(busy),
    .o_done(done), .o_result(result), .o_status(status),
    .o_ready(ready));
  flash_status_model u_flash (
    .i_ctl(ctl), .i_dq(host_dq), .i_load(load), .i_reads(reads),
    .i_fail(fail), .o_dq(dev_dq), .o_ready_busy_n(rb_n),
    .o_resets(resets));
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  // One polling pass against a device busy for n reads
  task automatic poll(input logic [7:0] n, input logic f, input logic ab,
                      input poll_result_e exp);
    int k;
    reads = n;
    fail = f;
    load = 1'b1;
    @(negedge i_clk);
    load = 1'b0;
    i_addr = 20'h1_2340;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      if (ab && k == 40) i_abort = 1'b1;
      if (ab && k > 41 && busy === 1'b0) break;
      if (ctl.oe_n === 1'b0) check(ctl.addr === 20'h1_2340, "addr");
      @(negedge i_clk);
    end
    i_abort = 1'b0;
    if (k == 3000) begin
      n_errors++;
      give_verdict();
    end
    check(result === exp, "result");
    @(negedge i_clk);
  endtask : poll
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    poll(8'h00, 1'b0, 1'b0, RES_OK);
    check(ready === 1'b1, "ready idle");
    check(status.toggle_one === 1'b0 && busy === 1'b0, "steady");
    poll(8'h05, 1'b0, 1'b0, RES_OK);
    poll(8'h00, 1'b1, 1'b0, RES_FAIL);
    check(resets === 1, "reset command");
    check(status.timing_limit === 1'b1, "limit flag");
    check(status.erase_timer === 1'b1, "timer bit");
    check(status.toggle_one && status.toggle_two, "toggles");
    poll(8'hFF, 1'b0, 1'b1, RES_ABORT);
    check(ready === 1'b0, "ready busy");
    check(resets === 1, "no reset on abort");
    poll(8'h03, 1'b0, 1'b0, RES_OK);
    give_verdict();
  end
endmodule : testbench
